/* File: hdl/gpp_consts.svh */
// Register addresses, reset values and bit-address bases for the port block.
`ifndef GPP_CONSTS_SVH
`define GPP_CONSTS_SVH
`define GPP_ADDR_P0_DATA      8'h80
`define GPP_ADDR_P1_DATA      8'h90
`define GPP_ADDR_P0_DRIVE     8'hA4
`define GPP_ADDR_P1_DRIVE     8'hA5
`define GPP_ADDR_P0_SKIP      8'hD4
`define GPP_ADDR_P1_SKIP      8'hD5
`define GPP_ADDR_P0_INMODE    8'hF1
`define GPP_ADDR_P1_INMODE    8'hF2
`define GPP_LATCH_RESET       8'hFF
`define GPP_DRIVE_RESET       8'h00
`define GPP_SKIP_RESET        8'h00
`define GPP_INMODE_RESET      8'hFF
`define GPP_BIT_BASE_P0       5'h10
`define GPP_BIT_BASE_P1       5'h12
`endif

/* File: hdl/gpp_pkg.sv */
// Types shared by the port block.
package gpp_pkg;
   typedef logic [7:0] gpp_byte_t;
   typedef enum logic [2:0] {
      GPP_REG_NONE   = 3'h0,
      GPP_REG_DATA   = 3'h1,
      GPP_REG_DRIVE  = 3'h2,
      GPP_REG_SKIP   = 3'h3,
      GPP_REG_INMODE = 3'h4
   } gpp_reg_e;
endpackage : gpp_pkg

/* File: hdl/gpp_sync.sv */
// Two-stage synchroniser for a bus of pin inputs.
`timescale 1ns/1ns
module gpp_sync #(
   parameter int W = 8
) (
   input  wire logic         sys_clk,
   input  wire logic         reset_n,
   input  wire logic         clk_en,
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);
   logic [W-1:0] meta_q;

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         meta_q   <= '0;
         sync_out <= '0;
      end else if (clk_en) begin
         meta_q   <= async_in;
         sync_out <= meta_q;
      end
   end
endmodule : gpp_sync

/* File: hdl/gpp_port.sv */
// Two general-purpose 8-bit ports with latches, drive modes and skip bits.
// Contract
// RULE_01: Pins not claimed by the crossbar and not analog act as plain I/O.
// RULE_02: Port data sits at 0x80 and 0x90, by byte and by bit access.
// RULE_03: A port write stores into an output latch that holds until rewritten.
// RULE_04: An ordinary port read returns pin levels, even for routed pins.
// RULE_05: Read-modify-write accesses read the latch, not the pins.
// RULE_06: The core flags all such instructions, including single-bit moves.
// RULE_07: Crossbar-assigned pins carry the peripheral signal, not the latch.
// RULE_08: Latch 0 drives low; latch 1 drives high or floats if open-drain.
// RULE_09: A pin in analog input mode reads as 0.
// RULE_10: A digital input pin reads its sampled level directly.
// RULE_11: Drive-type bit 0 selects open-drain, 1 selects push-pull.
// RULE_12: The drive-type bit is ignored while the pin is in analog mode.
// RULE_13: A skip bit of 1 makes the crossbar pass over that pin.
// RULE_14: Pin inputs pass a two-stage synchroniser before being read.
`timescale 1ns/1ns
`include "gpp_consts.svh"
module gpp_port #(
   parameter int W = 8
) (
   input  wire logic         sys_clk,
   input  wire logic         reset_n,
   input  wire logic         clk_en,
   input  wire logic [7:0]   sfr_addr,
   input  wire logic         sfr_bit,
   input  wire logic [7:0]   sfr_wdata,
   input  wire logic         sfr_wr,
   input  wire logic         sfr_rd,
   input  wire logic         sfr_rmw,
   output logic      [7:0]   sfr_rdata,
   output logic              sfr_hit,
   input  wire logic [W-1:0] p0_pin_in,
   output logic      [W-1:0] p0_pin_out,
   output logic      [W-1:0] p0_pin_oe,
   input  wire logic [W-1:0] p1_pin_in,
   output logic      [W-1:0] p1_pin_out,
   output logic      [W-1:0] p1_pin_oe,
   input  wire logic [W-1:0] p0_xbar_sel,
   input  wire logic [W-1:0] p0_xbar_out,
   input  wire logic [W-1:0] p0_xbar_oe,
   input  wire logic [W-1:0] p1_xbar_sel,
   input  wire logic [W-1:0] p1_xbar_out,
   input  wire logic [W-1:0] p1_xbar_oe,
   output logic      [W-1:0] p0_skip,
   output logic      [W-1:0] p1_skip,
   output logic      [W-1:0] p0_analog,
   output logic      [W-1:0] p1_analog
);
   gpp_pkg::gpp_byte_t p0_latch_q, p1_latch_q;
   gpp_pkg::gpp_byte_t p0_drive_q, p1_drive_q;
   gpp_pkg::gpp_byte_t p0_skip_q, p1_skip_q;
   gpp_pkg::gpp_byte_t p0_inmode_q, p1_inmode_q;
   logic [W-1:0] p0_sync, p1_sync;
   gpp_pkg::gpp_reg_e   sel;
   logic                sel_p1;
   logic [2:0]          bit_idx;
   gpp_pkg::gpp_byte_t  rd_d;

   // Pins cross into the clock domain before anything reads them.
   gpp_sync #(.W(W)) u_sync0 ( // RULE_14
      .sys_clk  (sys_clk),
      .reset_n  (reset_n),
      .clk_en   (clk_en),
      .async_in (p0_pin_in),
      .sync_out (p0_sync)
   );
   gpp_sync #(.W(W)) u_sync1 (
      .sys_clk  (sys_clk),
      .reset_n  (reset_n),
      .clk_en   (clk_en),
      .async_in (p1_pin_in),
      .sync_out (p1_sync)
   );

   // Bit addresses 0x80..0x87 and 0x90..0x97 map to the two port bytes.
   function automatic logic [2:0] decode(input logic [7:0] a,
                                         input logic       bit_mode);
      logic [2:0] r;
      r = 3'h0;
      if (bit_mode) begin
         if (a[7:3] == `GPP_BIT_BASE_P0)
            r = 3'h1;
         else if (a[7:3] == `GPP_BIT_BASE_P1)
            r = 3'h2;
      end else begin
         unique case (a)
            `GPP_ADDR_P0_DATA:   r = 3'h1;
            `GPP_ADDR_P1_DATA:   r = 3'h2;
            `GPP_ADDR_P0_DRIVE:  r = 3'h3;
            `GPP_ADDR_P1_DRIVE:  r = 3'h4;
            `GPP_ADDR_P0_SKIP:   r = 3'h5;
            `GPP_ADDR_P1_SKIP:   r = 3'h6;
            `GPP_ADDR_P0_INMODE: r = 3'h7;
            default:             r = 3'h0;
         endcase
      end
      return r;
   endfunction : decode

   logic [2:0] code;
   logic       p1_inmode_hit;

   always_comb begin
      code          = decode(sfr_addr, sfr_bit); // RULE_02
      p1_inmode_hit = !sfr_bit && (sfr_addr == `GPP_ADDR_P1_INMODE);
      bit_idx       = sfr_addr[2:0];
      sel_p1        = 1'b0;
      sel           = gpp_pkg::GPP_REG_NONE;
      unique case (code)
         3'h1: sel = gpp_pkg::GPP_REG_DATA;
         3'h2: begin
            sel    = gpp_pkg::GPP_REG_DATA;
            sel_p1 = 1'b1;
         end
         3'h3: sel = gpp_pkg::GPP_REG_DRIVE;
         3'h4: begin
            sel    = gpp_pkg::GPP_REG_DRIVE;
            sel_p1 = 1'b1;
         end
         3'h5: sel = gpp_pkg::GPP_REG_SKIP;
         3'h6: begin
            sel    = gpp_pkg::GPP_REG_SKIP;
            sel_p1 = 1'b1;
         end
         3'h7: sel = gpp_pkg::GPP_REG_INMODE;
         default: begin
            if (p1_inmode_hit) begin
               sel    = gpp_pkg::GPP_REG_INMODE;
               sel_p1 = 1'b1;
            end
         end
      endcase
   end

   assign sfr_hit = (sel != gpp_pkg::GPP_REG_NONE);

   // Digital read value: analog pins read 0, others read the pin.
   gpp_pkg::gpp_byte_t p0_pinval, p1_pinval;
   assign p0_pinval = p0_sync & p0_inmode_q; // RULE_09 RULE_10 RULE_04
   assign p1_pinval = p1_sync & p1_inmode_q;

   always_comb begin
      rd_d = 8'h00;
      unique case (sel)
         gpp_pkg::GPP_REG_DATA: begin
            if (sfr_rmw) // RULE_05 RULE_06
               rd_d = sel_p1 ? p1_latch_q : p0_latch_q;
            else
               rd_d = sel_p1 ? p1_pinval : p0_pinval;
         end
         gpp_pkg::GPP_REG_DRIVE:  rd_d = sel_p1 ? p1_drive_q : p0_drive_q;
         gpp_pkg::GPP_REG_SKIP:   rd_d = sel_p1 ? p1_skip_q : p0_skip_q;
         gpp_pkg::GPP_REG_INMODE: rd_d = sel_p1 ? p1_inmode_q : p0_inmode_q;
         gpp_pkg::GPP_REG_NONE:   rd_d = 8'h00;
      endcase
      // Bit reads return the addressed bit in position 0.
      if (sfr_bit)
         rd_d = {7'h00, rd_d[bit_idx]};
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n)
         sfr_rdata <= 8'h00;
      else if (clk_en && sfr_rd)
         sfr_rdata <= rd_d;
   end

   // Returns a byte with one bit replaced, for bit-addressed writes.
   function automatic logic [7:0] merge(input logic [7:0] old,
                                        input logic [2:0] idx,
                                        input logic       v);
      logic [7:0] r;
      r      = old;
      r[idx] = v;
      return r;
   endfunction : merge

   logic wr_go;
   assign wr_go = clk_en && sfr_wr;

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         p0_latch_q <= `GPP_LATCH_RESET;
         p1_latch_q <= `GPP_LATCH_RESET;
      end else if (wr_go && sel == gpp_pkg::GPP_REG_DATA) begin // RULE_03
         if (!sel_p1)
            p0_latch_q <= sfr_bit ? merge(p0_latch_q, bit_idx, sfr_wdata[0])
                                  : sfr_wdata;
         else
            p1_latch_q <= sfr_bit ? merge(p1_latch_q, bit_idx, sfr_wdata[0])
                                  : sfr_wdata;
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         p0_drive_q <= `GPP_DRIVE_RESET;
         p1_drive_q <= `GPP_DRIVE_RESET;
      end else if (wr_go && sel == gpp_pkg::GPP_REG_DRIVE) begin
         if (sel_p1)
            p1_drive_q <= sfr_wdata;
         else
            p0_drive_q <= sfr_wdata;
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         p0_skip_q <= `GPP_SKIP_RESET;
         p1_skip_q <= `GPP_SKIP_RESET;
      end else if (wr_go && sel == gpp_pkg::GPP_REG_SKIP) begin
         if (sel_p1)
            p1_skip_q <= sfr_wdata;
         else
            p0_skip_q <= sfr_wdata;
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         p0_inmode_q <= `GPP_INMODE_RESET;
         p1_inmode_q <= `GPP_INMODE_RESET;
      end else if (wr_go && sel == gpp_pkg::GPP_REG_INMODE) begin
         if (sel_p1)
            p1_inmode_q <= sfr_wdata;
         else
            p0_inmode_q <= sfr_wdata;
      end
   end

   assign p0_skip   = p0_skip_q; // RULE_13
   assign p1_skip   = p1_skip_q;
   assign p0_analog = ~p0_inmode_q;
   assign p1_analog = ~p1_inmode_q;

   // Pin drivers; crossbar signals take over selected pins, analog floats.
   genvar g;
   generate
      for (g = 0; g < W; g++) begin : g_pin
         always_comb begin
            if (!p0_inmode_q[g]) begin // RULE_12
               p0_pin_out[g] = 1'b0;
               p0_pin_oe[g]  = 1'b0;
            end else if (p0_xbar_sel[g]) begin // RULE_07
               p0_pin_out[g] = p0_xbar_out[g];
               p0_pin_oe[g]  = p0_xbar_oe[g];
            end else begin // RULE_01 RULE_08 RULE_11
               p0_pin_out[g] = p0_latch_q[g];
               p0_pin_oe[g]  = !p0_latch_q[g] || p0_drive_q[g];
            end
            if (!p1_inmode_q[g]) begin
               p1_pin_out[g] = 1'b0;
               p1_pin_oe[g]  = 1'b0;
            end else if (p1_xbar_sel[g]) begin
               p1_pin_out[g] = p1_xbar_out[g];
               p1_pin_oe[g]  = p1_xbar_oe[g];
            end else begin
               p1_pin_out[g] = p1_latch_q[g];
               p1_pin_oe[g]  = !p1_latch_q[g] || p1_drive_q[g];
            end
         end
      end
   endgenerate

   property p_opendrain_float;
      @(posedge sys_clk) disable iff (!reset_n)
      (p0_inmode_q[0] && !p0_xbar_sel[0] && p0_latch_q[0]
       && !p0_drive_q[0]) |-> !p0_pin_oe[0];
   endproperty
   a_opendrain_float: assert property (p_opendrain_float) // RULE_08
      else $error("open-drain high pin is driven");

   property p_write_latch;
      @(posedge sys_clk) disable iff (!reset_n)
      (clk_en && sfr_wr && !sfr_bit && sfr_addr == `GPP_ADDR_P0_DATA)
      |=> p0_latch_q == $past(sfr_wdata);
   endproperty
   a_write_latch: assert property (p_write_latch) // RULE_03
      else $error("port write not latched");

   property p_rmw_reads_latch;
      @(posedge sys_clk) disable iff (!reset_n)
      (clk_en && sfr_rd && sfr_rmw && !sfr_bit
       && sfr_addr == `GPP_ADDR_P1_DATA) |=> sfr_rdata == $past(p1_latch_q);
   endproperty
   a_rmw_reads_latch: assert property (p_rmw_reads_latch) // RULE_05
      else $error("rmw read did not return latch");

   property p_analog_zero;
      @(posedge sys_clk) disable iff (!reset_n)
      (clk_en && sfr_rd && !sfr_rmw && sfr_bit && sfr_addr[7:3]
       == `GPP_BIT_BASE_P0 && !p0_inmode_q[sfr_addr[2:0]])
      |=> sfr_rdata == 8'h00;
   endproperty
   a_analog_zero: assert property (p_analog_zero) // RULE_09
      else $error("analog pin read nonzero");

   property p_pin_read;
      @(posedge sys_clk) disable iff (!reset_n)
      (clk_en && sfr_rd && !sfr_rmw && !sfr_bit
       && sfr_addr == `GPP_ADDR_P0_DATA)
      |=> sfr_rdata == ($past(p0_sync) & $past(p0_inmode_q));
   endproperty
   a_pin_read: assert property (p_pin_read) // RULE_04
      else $error("pin read mismatch");

   property p_xbar_route;
      @(posedge sys_clk) disable iff (!reset_n)
      (p1_inmode_q[1] && p1_xbar_sel[1])
      |-> (p1_pin_out[1] == p1_xbar_out[1] && p1_pin_oe[1] == p1_xbar_oe[1]);
   endproperty
   a_xbar_route: assert property (p_xbar_route) // RULE_07
      else $error("crossbar pin not routed");

   property p_pushpull;
      @(posedge sys_clk) disable iff (!reset_n)
      (p0_inmode_q[2] && !p0_xbar_sel[2] && p0_drive_q[2])
      |-> (p0_pin_oe[2] && p0_pin_out[2] == p0_latch_q[2]);
   endproperty
   a_pushpull: assert property (p_pushpull) // RULE_11
      else $error("push-pull pin not driven");

   property p_analog_float;
      @(posedge sys_clk) disable iff (!reset_n)
      !p1_inmode_q[3] |-> !p1_pin_oe[3];
   endproperty
   a_analog_float: assert property (p_analog_float) // RULE_12
      else $error("analog pin driven");

   property p_bit_write;
      @(posedge sys_clk) disable iff (!reset_n)
      (clk_en && sfr_wr && sfr_bit && sfr_addr == 8'h91)
      |=> (p1_latch_q[1] == $past(sfr_wdata[0])
           && p1_latch_q[0] == $past(p1_latch_q[0])
           && p1_latch_q[7:2] == $past(p1_latch_q[7:2]));
   endproperty
   a_bit_write: assert property (p_bit_write) // RULE_02
      else $error("bit write wrong");

   property p_skip_out;
      @(posedge sys_clk) disable iff (!reset_n)
      (clk_en && sfr_wr && !sfr_bit && sfr_addr == `GPP_ADDR_P0_SKIP)
      |=> p0_skip == $past(sfr_wdata);
   endproperty
   a_skip_out: assert property (p_skip_out) // RULE_13
      else $error("skip bits not applied");
endmodule : gpp_port

/* File: dv/gpp_board.sv */
// Board model that resolves the level on each pin of one port.
`timescale 1ns/1ns
module gpp_board (
   input  wire logic [7:0] oe,
   input  wire logic [7:0] dout,
   input  wire logic [7:0] ext_en,
   input  wire logic [7:0] ext_val,
   output logic      [7:0] level
);
   // A pin that nobody drives settles to its weak pull-up level.
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         if (oe[i])
            level[i] = dout[i];
         else if (ext_en[i])
            level[i] = ext_val[i];
         else
            level[i] = 1'b1;
      end
   end
endmodule : gpp_board

/* File: dv/general_purpose_port_io_tb_top.sv */
// Self-checking testbench for the two-port block.
`timescale 1ns/1ns
`include "gpp_consts.svh"
module general_purpose_port_io_tb_top;
   logic       sys_clk, reset_n, sfr_bit, sfr_wr, sfr_rd, sfr_rmw;
   logic [7:0] sfr_addr, sfr_wdata, sfr_rdata;
   logic       sfr_hit;
   logic [7:0] p0_in, p0_out, p0_oe, p1_in, p1_out, p1_oe;
   logic [7:0] x0_sel, x0_out, x0_oe, p0_skip, p1_skip, p0_ana, p1_ana;
   logic [7:0] e0_en, e0_val, e1_en, e1_val, rv;
   logic       hv, ce;
   logic [7:0] x1_sel, x1_out, x1_oe;
   int         n_mismatch, checked;

   gpp_port #(.W(8)) DUT (.sys_clk(sys_clk), .reset_n(reset_n),
      .clk_en(ce), .sfr_addr(sfr_addr), .sfr_bit(sfr_bit),
      .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
      .sfr_rmw(sfr_rmw), .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit),
      .p0_pin_in(p0_in), .p0_pin_out(p0_out), .p0_pin_oe(p0_oe),
      .p1_pin_in(p1_in), .p1_pin_out(p1_out), .p1_pin_oe(p1_oe),
      .p0_xbar_sel(x0_sel), .p0_xbar_out(x0_out), .p0_xbar_oe(x0_oe),
      .p1_xbar_sel(x1_sel), .p1_xbar_out(x1_out), .p1_xbar_oe(x1_oe),
      .p0_skip(p0_skip), .p1_skip(p1_skip),
      .p0_analog(p0_ana), .p1_analog(p1_ana));
   gpp_board B0 (.oe(p0_oe), .dout(p0_out), .ext_en(e0_en),
      .ext_val(e0_val), .level(p0_in));
   gpp_board B1 (.oe(p1_oe), .dout(p1_out), .ext_en(e1_en),
      .ext_val(e1_val), .level(p1_in));

   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end

   task automatic check(input logic [7:0] seen, input logic [7:0] exp,
                        input string msg);
      checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: %s seen %h expected %h",
                  $time, msg, seen, exp);
      end
   endtask : check

   // One bus cycle: request held until the taking edge, data sampled after.
   task automatic acc(input logic [7:0] a, input logic b,
                      input logic [7:0] d, input logic w, input logic m);
      @(posedge sys_clk);
      sfr_addr  <= a;
      sfr_bit   <= b;
      sfr_wdata <= d;
      sfr_wr    <= w;
      sfr_rd    <= ~w;
      sfr_rmw   <= m;
      #1 hv = sfr_hit;
      @(posedge sys_clk);
      sfr_wr  <= 1'b0;
      sfr_rd  <= 1'b0;
      sfr_rmw <= 1'b0;
      #1 rv = sfr_rdata;
   endtask : acc

   task automatic t_reset;
      acc(`GPP_ADDR_P0_DRIVE, 1'b0, 8'h00, 1'b0, 1'b0);
      check(rv, `GPP_DRIVE_RESET, "drive reset");
      check({7'h00, hv}, 8'h01, "mapped hit");
      acc(`GPP_ADDR_P0_SKIP, 1'b0, 8'h00, 1'b0, 1'b0);
      check(rv, `GPP_SKIP_RESET, "skip reset");
      check(p0_oe, 8'h00, "reset oe");
      acc(`GPP_ADDR_P0_DATA, 1'b0, 8'h00, 1'b0, 1'b1);
      check(rv, `GPP_LATCH_RESET, "latch reset");
      acc(8'h33, 1'b0, 8'h00, 1'b0, 1'b0);
      check(rv, 8'h00, "unmapped read");
      check({7'h00, hv}, 8'h00, "unmapped hit");
      $display("test reset done");
   endtask : t_reset

   task automatic t_latch;
      e0_en <= 8'hFF;
      e0_val <= 8'h0F;
      acc(`GPP_ADDR_P0_DATA, 1'b0, 8'h55, 1'b1, 1'b0);
      check(p0_oe, 8'hAA, "open-drain oe");
      check(p0_out & 8'hAA, 8'h00, "low drive");
      // The new pin levels need two edges to cross the synchroniser.
      repeat (2) @(posedge sys_clk);
      acc(`GPP_ADDR_P0_DATA, 1'b0, 8'h00, 1'b0, 1'b0);
      check(rv, 8'h05, "pin read");
      acc(`GPP_ADDR_P0_DATA, 1'b0, 8'h00, 1'b0, 1'b1);
      check(rv, 8'h55, "rmw read");
      acc(`GPP_ADDR_P0_DRIVE, 1'b0, 8'h0F, 1'b1, 1'b0);
      check(p0_oe, 8'hAF, "push-pull oe");
      check(p0_out & 8'hAF, 8'h05, "push-pull out");
      $display("test latch done");
   endtask : t_latch

   task automatic t_analog;
      e0_val <= 8'hFF;
      acc(`GPP_ADDR_P0_INMODE, 1'b0, 8'hF0, 1'b1, 1'b0);
      check(p0_ana, 8'h0F, "analog map");
      check(p0_oe, 8'hA0, "analog oe");
      acc(`GPP_ADDR_P0_DATA, 1'b0, 8'h00, 1'b0, 1'b0);
      check(rv, 8'h50, "analog read");
      acc(8'h80, 1'b1, 8'h00, 1'b0, 1'b0);
      check(rv, 8'h00, "analog bit read");
      acc(8'h84, 1'b1, 8'h00, 1'b0, 1'b0);
      check(rv, 8'h01, "digital bit read");
      acc(`GPP_ADDR_P0_INMODE, 1'b0, 8'hFF, 1'b1, 1'b0);
      acc(`GPP_ADDR_P1_INMODE, 1'b0, 8'h7F, 1'b1, 1'b0);
      check(p1_ana, 8'h80, "second analog map");
      acc(`GPP_ADDR_P1_INMODE, 1'b0, 8'hFF, 1'b1, 1'b0);
      $display("test analog done");
   endtask : t_analog

   task automatic t_bit;
      acc(8'h91, 1'b1, 8'h00, 1'b1, 1'b0);
      check(p1_oe, 8'h02, "bit write oe");
      acc(8'h91, 1'b1, 8'h00, 1'b0, 1'b1);
      check(rv & 8'h01, 8'h00, "bit read 1");
      acc(8'h90, 1'b1, 8'h00, 1'b0, 1'b1);
      check(rv & 8'h01, 8'h01, "bit read 0");
      acc(`GPP_ADDR_P1_DATA, 1'b0, 8'h00, 1'b0, 1'b1);
      check(rv, 8'hFD, "byte after bit");
      acc(`GPP_ADDR_P1_DRIVE, 1'b0, 8'h01, 1'b1, 1'b0);
      check(p1_oe, 8'h03, "second push-pull oe");
      acc(`GPP_ADDR_P1_DRIVE, 1'b0, 8'h00, 1'b1, 1'b0);
      $display("test bit done");
   endtask : t_bit

   task automatic t_xbar;
      @(posedge sys_clk);
      x0_sel <= 8'h01;
      x0_out <= 8'h00;
      x0_oe  <= 8'h01;
      x1_sel <= 8'h02;
      x1_out <= 8'h02;
      x1_oe  <= 8'h02;
      repeat (2) @(posedge sys_clk);
      acc(`GPP_ADDR_P0_DATA, 1'b0, 8'h00, 1'b0, 1'b0);
      check(p0_out & 8'h01, 8'h00, "xbar out");
      check(p0_oe & 8'h01, 8'h01, "xbar oe");
      check(rv, 8'h54, "routed read");
      check(p1_out & 8'h02, 8'h02, "second xbar out");
      check(p1_oe & 8'h02, 8'h02, "second xbar oe");
      @(posedge sys_clk);
      x0_sel <= 8'h00;
      x1_sel <= 8'h00;
      acc(`GPP_ADDR_P0_DATA, 1'b0, 8'h00, 1'b0, 1'b1);
      check(rv, 8'h55, "latch kept");
      check(p0_out & 8'h01, 8'h01, "gpio restored");
      $display("test xbar done");
   endtask : t_xbar

   task automatic t_skip;
      acc(`GPP_ADDR_P0_SKIP, 1'b0, 8'h3C, 1'b1, 1'b0);
      acc(`GPP_ADDR_P0_SKIP, 1'b0, 8'h00, 1'b0, 1'b0);
      check(rv, 8'h3C, "skip read");
      check(p0_skip, 8'h3C, "skip out");
      acc(`GPP_ADDR_P1_SKIP, 1'b0, 8'hC3, 1'b1, 1'b0);
      check(p1_skip, 8'hC3, "second skip out");
      // With the clock enable low a write must leave the register alone.
      @(posedge sys_clk);
      ce <= 1'b0;
      acc(`GPP_ADDR_P0_SKIP, 1'b0, 8'h00, 1'b1, 1'b0);
      check(p0_skip, 8'h3C, "frozen skip");
      @(posedge sys_clk);
      ce <= 1'b1;
      $display("test skip done");
   endtask : t_skip

   task automatic t_sync;
      e1_en <= 8'hFF;
      e1_val <= 8'h00;
      repeat (3) @(posedge sys_clk);
      e1_val <= 8'hFF;
      acc(`GPP_ADDR_P1_DATA, 1'b0, 8'h00, 1'b0, 1'b0);
      check(rv, 8'h00, "sync delay");
      acc(`GPP_ADDR_P1_DATA, 1'b0, 8'h00, 1'b0, 1'b0);
      check(rv, 8'hFD, "sync settled");
      $display("test sync done");
   endtask : t_sync

   task automatic results;
      $display("comparisons %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : results

   initial begin
      #(3000 * 50);
      n_mismatch++;
      results();
   end

   initial begin
      n_mismatch = 0;
      checked = 0;
      reset_n = 1'b0;
      {sfr_bit, sfr_wr, sfr_rd, sfr_rmw} = 4'h0;
      sfr_addr = 8'h00;
      sfr_wdata = 8'h00;
      ce = 1'b1;
      {x0_sel, x0_out, x0_oe} = 24'h000000;
      {x1_sel, x1_out, x1_oe} = 24'h000000;
      {e0_en, e0_val, e1_en, e1_val} = 32'h00000000;
      repeat (12) @(posedge sys_clk);
      reset_n <= 1'b1;
      repeat (3) @(posedge sys_clk);
      t_reset();
      t_latch();
      t_analog();
      t_bit();
      t_xbar();
      t_skip();
      t_sync();
      results();
   end
endmodule : general_purpose_port_io_tb_top
